// >>> hdl/rscr_top.sv
/*
  Reset strap capture and clock ratio selection with an APB register slave.
  Assumes straps are held by board resistors or reset logic around reset
  release, and an APB master on pclk.
*/
`timescale 1ns/1ps
`include "rscr_consts.svh"

// What this block does
// - Platform to reference ratio fixed by four platform strap lines.
// - Decode platform code to 16,2..6,8,9,10,12; other codes reserved.
// - Core to platform ratio fixed by two core strap lines.
// - Core code 00,01,10,11 gives 2, 2.5, 3, 3.5 times platform.
// - Platform clock drives cache, core bus and DDR data rate.
// - Memory bus clock runs at half the platform clock.
// - Weak strap pull-ups enabled from reset until the straps are captured.
module rscr_top
  import rscr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] platform_ratio_straps,
  input wire logic core_ratio_strap_hi,
  input wire logic core_ratio_strap_lo,
  input wire logic pci_width_strap_n,
  output logic strap_pullup_en,
  output logic cfg_done,
  output logic cfg_valid,
  output logic plat_code_reserved,
  output logic [4:0] plat_ratio,
  output logic [2:0] core_ratio_half,
  output logic [7:0] core_ref_ratio_half,
  output logic [4:0] ddr_rate_ratio,
  output logic [4:0] mem_ratio_x2,
  output logic pci_64bit
);
  logic [6:0] strap_sync;
  logic [3:0] pcode_s;
  logic [1:0] ccode_s;
  logic pciw_s;
  rscr_state_type state_q;
  logic [1:0] cnt_q;
  logic capture;
  logic [3:0] pcode_q;
  logic [1:0] ccode_q;
  logic [4:0] plat_d;
  logic rsvd_d;
  logic [4:0] plat_q;
  logic rsvd_q;
  logic [2:0] chalf_q;
  logic [7:0] cref_q;
  logic [4:0] ddr_q;
  logic [4:0] mem_q;
  logic pci64_q;
  logic pullup_q;
  logic done_q;
  logic apply_q;
  logic valid_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic wr_commit;

  rscr_sync #(.W(7)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({pci_width_strap_n, core_ratio_strap_hi, core_ratio_strap_lo, platform_ratio_straps}),
    .dout(strap_sync)
  );
  assign pcode_s = strap_sync[3:0];
  assign ccode_s = strap_sync[5:4];
  assign pciw_s = strap_sync[6];

  // Capture sequencer: wait out the synchroniser, then latch once
  assign capture = (state_q == RSCR_SETTLE) && (cnt_q == `RSCR_SETTLE_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RSCR_SETTLE;
      cnt_q <= 2'h0;
    end else begin
      unique case (state_q)
        RSCR_SETTLE: begin
          cnt_q <= cnt_q + 2'h1;
          if (capture) begin
            state_q <= RSCR_DONE;
          end
        end
        RSCR_DONE: begin
          state_q <= RSCR_DONE;
        end
        default: begin
          state_q <= RSCR_SETTLE;
        end
      endcase
    end
  end

  always_comb begin
    rsvd_d = 1'b0;
    plat_d = 5'h00;
    unique case (pcode_s)
      4'h0: plat_d = 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: plat_d = {1'b0, pcode_s};
      default: rsvd_d = 1'b1;
    endcase
  end

  // latch once after release, hold until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcode_q <= 4'h0;
      ccode_q <= 2'h0;
      plat_q <= 5'h00;
      rsvd_q <= 1'b0;
      chalf_q <= 3'h0;
      cref_q <= 8'h00;
      ddr_q <= 5'h00;
      mem_q <= 5'h00;
      pci64_q <= 1'b0;
    end else if (capture) begin
      pcode_q <= pcode_s;
      plat_q <= plat_d;
      rsvd_q <= rsvd_d;
      ccode_q <= ccode_s;
      chalf_q <= `RSCR_CORE_HALF_BASE + {1'b0, ccode_s};
      cref_q <= 8'(plat_d * (`RSCR_CORE_HALF_BASE + {1'b0, ccode_s}));
      ddr_q <= plat_d;
      mem_q <= plat_d;
      pci64_q <= ~pciw_s;
    end
  end

  // Done flag kept in a flop so the output is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (capture) begin
      done_q <= 1'b1;
    end
  end

  // pull-ups only until straps are taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_q <= 1'b1;
    end else if (capture) begin
      pullup_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= (state_q == RSCR_DONE) && apply_q && !rsvd_q;
    end
  end

  // APB slave: decode in setup, answer in first access cycle
  assign setup = psel && !penable;
  assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
        unique case (paddr)
          `RSCR_OFF_CTRL: prdata_q[`RSCR_CTRL_APPLY_BIT] <= apply_q;
          `RSCR_OFF_STATUS: begin
            prdata_q[`RSCR_ST_DONE_BIT] <= (state_q == RSCR_DONE);
            prdata_q[`RSCR_ST_RSVD_BIT] <= rsvd_q;
            prdata_q[`RSCR_ST_PCI64_BIT] <= pci64_q;
            prdata_q[`RSCR_ST_PCODE_LSB +: 4] <= pcode_q;
            prdata_q[`RSCR_ST_CCODE_LSB +: 2] <= ccode_q;
          end
          `RSCR_OFF_RATIO: begin
            prdata_q[`RSCR_RT_PLAT_LSB +: 5] <= plat_q;
            prdata_q[`RSCR_RT_CORE_LSB +: 3] <= chalf_q;
            prdata_q[`RSCR_RT_CREF_LSB +: 8] <= cref_q;
          end
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apply_q <= `RSCR_CTRL_RESET;
    end else if (wr_commit && paddr == `RSCR_OFF_CTRL) begin
      apply_q <= pwdata[`RSCR_CTRL_APPLY_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign strap_pullup_en = pullup_q;
  assign cfg_done = done_q;
  assign cfg_valid = valid_q;
  assign plat_code_reserved = rsvd_q;
  assign plat_ratio = plat_q;
  assign core_ratio_half = chalf_q;
  assign core_ref_ratio_half = cref_q;
  assign ddr_rate_ratio = ddr_q;
  assign mem_ratio_x2 = mem_q;
  assign pci_64bit = pci64_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_plat_capture: assert property ($rose(cfg_done) |-> pcode_q == $past(pcode_s))
    else $error("platform code not taken from straps");
  a_plat_decode: assert property (cfg_done && pcode_q == 4'h0 |-> plat_q == 5'h10 && !rsvd_q)
    else $error("platform code decode wrong");
  a_plat_rsvd: assert property (cfg_done && (pcode_q == 4'h7 || pcode_q == 4'hb) |-> rsvd_q)
    else $error("reserved platform code not flagged");
  a_core_capture: assert property ($rose(cfg_done) |-> ccode_q == $past(ccode_s))
    else $error("core code not taken from straps");
  a_core_decode: assert property (cfg_done |-> chalf_q == {1'b0, ccode_q} + 3'h4)
    else $error("core ratio decode wrong");
  a_ddr_follow: assert property (cfg_done |-> ddr_q == plat_q && cref_q == 8'(plat_q * chalf_q))
    else $error("ddr rate or core ref ratio wrong");
  a_mem_half: assert property (cfg_done |-> mem_q == plat_q)
    else $error("memory bus ratio not half of platform");
  a_pullup_window: assert property (strap_pullup_en |-> ##[0:3] cfg_done ##0 !strap_pullup_en)
    else $error("pull-up window wrong");
  a_ratio_hold: assert property (cfg_done ##1 cfg_done |-> $stable(plat_q) && $stable(chalf_q))
    else $error("ratios changed after capture");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

  c_done: cover property ($rose(cfg_done));
  c_reserved: cover property (cfg_done && rsvd_q);
  c_ctrl_write: cover property (wr_commit && paddr == `RSCR_OFF_CTRL && !pwdata[0]);
endmodule

// >>> hdl/rscr_consts.svh
/*
  Register offsets, field positions, reset values and counts for the
  reset strap clock ratio block. Assumes inclusion by bare name.
*/
`ifndef RSCR_CONSTS_SVH
`define RSCR_CONSTS_SVH

`define RSCR_OFF_CTRL 8'h00
`define RSCR_OFF_STATUS 8'h04
`define RSCR_OFF_RATIO 8'h08

`define RSCR_CTRL_APPLY_BIT 0
`define RSCR_CTRL_RESET 1'b1

`define RSCR_ST_DONE_BIT 0
`define RSCR_ST_RSVD_BIT 1
`define RSCR_ST_PCI64_BIT 2
`define RSCR_ST_PCODE_LSB 4
`define RSCR_ST_CCODE_LSB 8

`define RSCR_RT_PLAT_LSB 0
`define RSCR_RT_CORE_LSB 8
`define RSCR_RT_CREF_LSB 16

`define RSCR_SETTLE_CYC 2'd2
`define RSCR_CORE_HALF_BASE 3'h4

`endif

// >>> hdl/rscr_pkg.sv
/*
  Types shared by the reset strap clock ratio block.
  Assumes the constants header is compiled alongside.
*/
package rscr_pkg;
  typedef enum logic [1:0] {
    RSCR_SETTLE = 2'b01,
    RSCR_DONE = 2'b10
  } rscr_state_type;
endpackage

// >>> hdl/rscr_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes pins are quasi-static straps; reset value is zero.
*/
`timescale 1ns/1ps
module rscr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// >>> bench/rscr_strap_model.sv
/*
  Board strap model: drives the strap pins through reset release.
  Assumes the block samples by the third edge after release.
*/
`timescale 1ns/1ps
module rscr_strap_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] plat_code,
  input wire logic [1:0] core_code,
  input wire logic want_pci64,
  output logic [3:0] platform_ratio_straps,
  output logic core_ratio_strap_hi,
  output logic core_ratio_strap_lo,
  output logic pci_width_strap_n
);
  logic [1:0] hold_q;
  logic flip_q;
  logic busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 2'd0;
      flip_q <= 1'b0;
    end else if (hold_q != 2'd3) begin
      hold_q <= hold_q + 2'd1;
    end else begin
      flip_q <= ~flip_q;
    end
  end
  // Pins reused after hold, so they keep changing
  assign busy = (hold_q == 2'd3);
  assign platform_ratio_straps = busy ? (plat_code ^ {4{~flip_q}}) : plat_code;
  assign core_ratio_strap_hi = busy ? (core_code[1] ^ ~flip_q) : core_code[1];
  assign core_ratio_strap_lo = busy ? (core_code[0] ^ ~flip_q) : core_code[0];
  assign pci_width_strap_n = busy ? flip_q : ~want_pci64;
endmodule

// >>> bench/rscr_top_tb_top.sv
/*
  Testbench for the strap capture block: every platform code, one per reset.
  Assumes zero wait state APB and capture on the third edge.
*/
`timescale 1ns/1ps
`include "rscr_consts.svh"
module rscr_top_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st, rt;
  logic pready, pslverr, err, p64 = 1'b0, rs;
  logic [3:0] pc = 4'h0, platform_ratio_straps;
  logic [1:0] cc = 2'h0;
  logic core_ratio_strap_hi, core_ratio_strap_lo, pci_width_strap_n, strap_pullup_en;
  logic cfg_done, cfg_valid, plat_code_reserved, pci_64bit;
  logic [4:0] plat_ratio, ddr_rate_ratio, mem_ratio_x2, pe;
  logic [2:0] core_ratio_half, ch;
  logic [7:0] core_ref_ratio_half, cr;
  int n_fail = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  rscr_top rscr_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .platform_ratio_straps, .core_ratio_strap_hi,
    .core_ratio_strap_lo, .pci_width_strap_n, .strap_pullup_en, .cfg_done, .cfg_valid,
    .plat_code_reserved, .plat_ratio, .core_ratio_half, .core_ref_ratio_half,
    .ddr_rate_ratio, .mem_ratio_x2, .pci_64bit);
  rscr_strap_model rscr_strap_model_i (.pclk, .presetn, .plat_code(pc), .core_code(cc),
    .want_pci64(p64), .platform_ratio_straps, .core_ratio_strap_hi,
    .core_ratio_strap_lo, .pci_width_strap_n);
  function automatic logic [4:0] plat_exp(input logic [3:0] c);
    case (c)
      4'h0: return 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: return {1'b0, c};
      default: return 5'h00;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      pc <= i[3:0];
      cc <= i[2:1];
      p64 <= i[0];
      presetn <= 1'b0;
      pe = plat_exp(i[3:0]);
      rs = (pe == 5'h00);
      ch = 3'h4 + {1'b0, i[2:1]};
      cr = 8'(pe * ch);
      st = {22'h0, i[2:1], i[3:0], 1'b0, i[0], rs, 1'b1};
      rt = {8'h00, cr, 5'h00, ch, 3'h0, pe};
      repeat (6) @(posedge pclk);
      chk(strap_pullup_en, 32'h1);
      chk(cfg_done, 32'h0);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(strap_pullup_en, 32'h0);
      chk(cfg_done, 32'h1);
      chk(plat_ratio, pe);
      chk(plat_code_reserved, rs);
      chk(core_ratio_half, ch);
      chk(core_ref_ratio_half, cr);
      chk(ddr_rate_ratio, pe);
      chk(mem_ratio_x2, pe);
      chk(pci_64bit, i[0]);
      chk(cfg_valid, !rs);
      apb(1'b0, `RSCR_OFF_STATUS, 32'h0);
      chk(rd, st);
      apb(1'b1, `RSCR_OFF_RATIO, 32'hffffffff);
      apb(1'b0, `RSCR_OFF_RATIO, 32'h0);
      chk(rd, rt);
      chk(err, 32'h0);
      apb(1'b1, `RSCR_OFF_CTRL, 32'h0);
      apb(1'b0, `RSCR_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk(cfg_valid, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      chk(plat_ratio, pe);
      $display("test code %h done", i[3:0]);
    end
    stop_test();
  end
endmodule
